/* core/pec_regs.vh */
`ifndef PEC_REGS_VH
`define PEC_REGS_VH

// model register addresses
`define PEC_ADDR_CNT0 12'h0C1
`define PEC_ADDR_ALIAS0 12'h4C1
`define PEC_ADDR_SEL0 12'h186
`define PEC_ADDR_CAP 12'h345

// capability register fields
`define PEC_CAP_FW_BIT 13

// event select register fields
`define PEC_F_EVT 7:0
`define PEC_F_UMASK 15:8
`define PEC_F_CORE 15:14
`define PEC_F_AGENT 13
`define PEC_F_PF 13:12
`define PEC_F_STATE 11:8
`define PEC_F_USR 16
`define PEC_F_OS 17
`define PEC_F_EN 22
`define PEC_SEL_RST 32'h0000_0000

// pre-defined event codes
`define PEC_EV_CYCLES 8'h3C
`define PEC_EV_INSN 8'hC0
`define PEC_EV_LLC 8'h2E
`define PEC_EV_BR 8'hC4
`define PEC_EV_BRMISS 8'hC5
`define PEC_UM_NONE 8'h00
`define PEC_UM_REF 8'h01
`define PEC_UM_LLCREF 8'h4F
`define PEC_UM_LLCMISS 8'h41

// qualifier encodings
`define PEC_CORE_ALL 2'h3
`define PEC_CORE_THIS 2'h1
`define PEC_PF_ALL 2'h3
`define PEC_PF_ONLY 2'h1
`define PEC_PF_EXCL 2'h0

`endif

/* core/pec_top.v */
`default_nettype none
`include "pec_regs.vh"

module pec_top #(
  parameter NCNT = 2,
  parameter CNT_W = 48,
  parameter FW_CAP = 1,
  parameter [6:0] EVT_UNAVAIL = 7'h00
) (
  // clock and reset
  input wire mclk,
  input wire resetn,
  // model register write port
  input wire wr_en,
  input wire [11:0] wr_addr,
  input wire [31:0] wr_lo,
  input wire [31:0] wr_hi,
  output reg wr_err,
  // model register read port
  input wire rd_en,
  input wire [11:0] rd_addr,
  output reg [63:0] rd_data,
  output reg rd_valid,
  output reg rd_err,
  // counting control from outside this block
  input wire [NCNT-1:0] global_en,
  input wire ring0,
  // core state
  input wire sleep_non_c0,
  input wire halted,
  input wire stop_clock_pin,
  input wire first_level_thermal_throttle,
  input wire freq_switching,
  input wire ref_tick,
  // architectural event pulses
  input wire insn_retire,
  input wire vm_exit,
  input wire llc_ref,
  input wire llc_miss,
  input wire br_retire,
  input wire br_misp,
  // model-specific event pulse and its attributes
  input wire ms_evt,
  input wire [7:0] ms_code,
  input wire ms_q_core,
  input wire ms_q_agent,
  input wire ms_q_pf,
  input wire ms_q_state,
  input wire ms_this_core,
  input wire ms_this_agent,
  input wire ms_hw_pf,
  input wire [3:0] ms_line_state,
  // availability vector
  output wire [6:0] evt_unavail
);

  assign evt_unavail = EVT_UNAVAIL;

  // stop-clock arrives from a pin
  reg stop_clock_pin_meta_reg;
  reg stop_clock_pin_sync_reg;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stop_clock_pin_meta_reg <= 1'b0;
      stop_clock_pin_sync_reg <= 1'b0;
    end else begin
      stop_clock_pin_meta_reg <= stop_clock_pin;
      stop_clock_pin_sync_reg <= stop_clock_pin_meta_reg;
    end
  end

  // mclk is the core clock; core cycles stop counting while freq_switching is high
  wire core_run = !(sleep_non_c0 | halted | stop_clock_pin_sync_reg |
                    first_level_thermal_throttle | freq_switching);

  wire fw_on = (FW_CAP != 0);
  wire [63:0] cap_val = {{(63 - `PEC_CAP_FW_BIT){1'b0}}, fw_on,
                         {`PEC_CAP_FW_BIT{1'b0}}};

  // write values for both counter forms
  wire [63:0] narrow_val = {{32{wr_lo[31]}}, wr_lo};
  wire [63:0] wide_val = {wr_hi, wr_lo};

  // prefetch qualification never applies alongside agent qualification
  wire use_pf = ms_q_pf & !ms_q_agent;

  wire [NCNT-1:0] hit_cnt_w;
  wire [NCNT-1:0] hit_alias_w;
  wire [NCNT-1:0] hit_sel_w;
  wire [NCNT-1:0] hit_cnt_r;
  wire [NCNT-1:0] hit_alias_r;
  wire [NCNT-1:0] hit_sel_r;
  wire [NCNT*64-1:0] cnt_rd_flat;
  wire [NCNT*32-1:0] sel_rd_flat;

  genvar g;
  generate
    for (g = 0; g < NCNT; g = g + 1) begin : g_cnt
      localparam [11:0] A_CNT = `PEC_ADDR_CNT0 + g;
      localparam [11:0] A_ALIAS = `PEC_ADDR_ALIAS0 + g;
      localparam [11:0] A_SEL = `PEC_ADDR_SEL0 + g;

      reg [CNT_W-1:0] cnt_reg;
      reg [CNT_W-1:0] cnt_next;
      reg [31:0] sel_reg;

      assign hit_cnt_w[g] = (wr_addr == A_CNT);
      assign hit_alias_w[g] = fw_on & (wr_addr == A_ALIAS);
      assign hit_sel_w[g] = (wr_addr == A_SEL);
      assign hit_cnt_r[g] = (rd_addr == A_CNT);
      assign hit_alias_r[g] = fw_on & (rd_addr == A_ALIAS);
      assign hit_sel_r[g] = (rd_addr == A_SEL);

      wire [7:0] esel = sel_reg[`PEC_F_EVT];
      wire [7:0] umask = sel_reg[`PEC_F_UMASK];
      wire [1:0] core_q = sel_reg[`PEC_F_CORE];
      wire [1:0] pf_q = sel_reg[`PEC_F_PF];

      // pre-defined events
      wire is_cyc = (esel == `PEC_EV_CYCLES) & (umask == `PEC_UM_NONE);
      wire is_ref = (esel == `PEC_EV_CYCLES) & (umask == `PEC_UM_REF);
      wire is_insn = (esel == `PEC_EV_INSN) & (umask == `PEC_UM_NONE);
      wire is_lref = (esel == `PEC_EV_LLC) & (umask == `PEC_UM_LLCREF);
      wire is_lmiss = (esel == `PEC_EV_LLC) & (umask == `PEC_UM_LLCMISS);
      wire is_br = (esel == `PEC_EV_BR) & (umask == `PEC_UM_NONE);
      wire is_brm = (esel == `PEC_EV_BRMISS) & (umask == `PEC_UM_NONE);
      wire is_arch = is_cyc | is_ref | is_insn | is_lref | is_lmiss | is_br | is_brm;

      wire arch_hit = (is_cyc & core_run) |
                      (is_ref & ref_tick & core_run) |
                      (is_insn & insn_retire & !vm_exit) |
                      (is_lref & llc_ref) |
                      (is_lmiss & llc_miss) |
                      (is_br & br_retire) |
                      (is_brm & br_misp);

      // qualifier sub-fields; core-only sources flag neither core nor agent
      wire core_ok = !ms_q_core | (core_q == `PEC_CORE_ALL) |
                     ((core_q == `PEC_CORE_THIS) & ms_this_core);
      wire agent_ok = !ms_q_agent | sel_reg[`PEC_F_AGENT] | ms_this_agent;
      wire pf_ok = !use_pf | (pf_q == `PEC_PF_ALL) |
                   ((pf_q == `PEC_PF_ONLY) & ms_hw_pf) |
                   ((pf_q == `PEC_PF_EXCL) & !ms_hw_pf);
      wire state_ok = !ms_q_state |
                      (|(sel_reg[`PEC_F_STATE] & ms_line_state));

      wire ms_hit = !is_arch & ms_evt & (ms_code == esel) &
                    core_ok & agent_ok & pf_ok & state_ok;

      wire priv_ok = (sel_reg[`PEC_F_OS] & ring0) | (sel_reg[`PEC_F_USR] & !ring0);
      wire cnt_en = global_en[g] & sel_reg[`PEC_F_EN] & priv_ok;

      // a software write in the same cycle as an event wins over the count
      always @* begin
        cnt_next = cnt_reg;
        if (wr_en & hit_alias_w[g])
          cnt_next = wide_val[CNT_W-1:0];
        else if (wr_en & hit_cnt_w[g])
          cnt_next = narrow_val[CNT_W-1:0];
        else if (cnt_en & (arch_hit | ms_hit))
          cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end

      always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          cnt_reg <= {CNT_W{1'b0}};
          sel_reg <= `PEC_SEL_RST;
        end else begin
          cnt_reg <= cnt_next;
          if (wr_en & hit_sel_w[g])
            sel_reg <= wr_lo;
        end
      end

      // upper bits read back as the sign of the implemented width
      assign cnt_rd_flat[g*64 +: 64] = {{(64-CNT_W){cnt_reg[CNT_W-1]}}, cnt_reg};
      assign sel_rd_flat[g*32 +: 32] = sel_reg;
    end
  endgenerate

  // read mux
  reg [63:0] rd_mux;
  reg rd_hit;
  integer i;
  always @* begin
    rd_mux = 64'h0000_0000_0000_0000;
    rd_hit = 1'b0;
    if (rd_addr == `PEC_ADDR_CAP) begin
      rd_mux = cap_val;
      rd_hit = 1'b1;
    end
    for (i = 0; i < NCNT; i = i + 1) begin
      if (hit_cnt_r[i] | hit_alias_r[i]) begin
        rd_mux = cnt_rd_flat[i*64 +: 64];
        rd_hit = 1'b1;
      end
      if (hit_sel_r[i]) begin
        rd_mux = {32'h0000_0000, sel_rd_flat[i*32 +: 32]};
        rd_hit = 1'b1;
      end
    end
  end

  // capability register is read-only, so writing it is an error
  wire wr_hit = |(hit_cnt_w | hit_alias_w | hit_sel_w);

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 64'h0000_0000_0000_0000;
      rd_valid <= 1'b0;
      rd_err <= 1'b0;
      wr_err <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      rd_err <= rd_en & !rd_hit;
      wr_err <= wr_en & !wr_hit;
      if (rd_en)
        rd_data <= rd_mux;
    end
  end

endmodule // pec_top
`default_nettype wire

/* verif/pec_props.sv */
`default_nettype none
module pec_props #(
  parameter FW_CAP = 1,
  parameter [6:0] EVT_UNAVAIL = 7'h00
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register ports
  input wire logic wr_en,
  input wire logic [11:0] wr_addr,
  input wire logic [31:0] wr_lo,
  input wire logic wr_err,
  input wire logic rd_en,
  input wire logic [11:0] rd_addr,
  input wire logic [63:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_err,
  input wire logic [6:0] evt_unavail
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_cap_full_width: assert property (
    rd_en && rd_addr == 12'h345 |=> rd_valid && !rd_err && rd_data[13] == (FW_CAP != 0))
    else $error("capability bit wrong");
  a_cap_read_only: assert property (wr_en && wr_addr == 12'h345 |=> wr_err)
    else $error("capability write accepted");
  a_alias_mapped: assert property (
    rd_en && rd_addr inside {12'h4C1, 12'h4C2} |=> rd_err == (FW_CAP == 0))
    else $error("alias read mapping wrong");
  a_alias_write: assert property (
    wr_en && wr_addr inside {12'h4C1, 12'h4C2} |=> wr_err == (FW_CAP == 0))
    else $error("alias write mapping wrong");
  // low bound stays far from wrap, so later counting cannot clear the top half
  a_narrow_sext: assert property (
    wr_en && wr_addr == 12'h0C1 && wr_lo[31:30] == 2'h2 ##2 rd_en && rd_addr == 12'h0C1
    |=> rd_data[63:32] == 32'hFFFF_FFFF)
    else $error("narrow write not sign extended");
  a_read_error: assert property (rd_err |-> rd_valid && rd_data == 64'h0)
    else $error("error read carries data");
  a_write_error: assert property (wr_err |-> $past(wr_en) && $past(wr_addr) != 12'h0C1)
    else $error("counter write refused");
  a_unavail_vector: assert property (evt_unavail == EVT_UNAVAIL)
    else $error("availability vector wrong");
endmodule // pec_props
bind pec_top pec_props #(.FW_CAP(FW_CAP), .EVT_UNAVAIL(EVT_UNAVAIL)) u_pec_props (.*);
`default_nettype wire

/* verif/pec_src.sv */
`default_nettype none
module pec_src (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // event pulses and attributes toward the counters
  output logic [6:0] pulse,
  output logic [11:0] ms_attr,
  output logic [7:0] ms_code
);
  timeunit 1ns;
  timeprecision 1ps;
  integer seed = 32'h0a79;
  logic [31:0] r;
  initial {pulse, ms_attr, ms_code} = '0;
  always @(posedge mclk) begin
    r = $random(seed);
    // pulse is quiet in reset, ms_attr is not; a line is in exactly one coherency state
    pulse <= resetn ? r[6:0] : 7'h0;
    ms_attr <= {r[14:7], 4'h1 << r[16:15]};
    ms_code <= r[17] ? 8'h80 : 8'h81;
  end
endmodule // pec_src
`default_nettype wire

/* verif/pec_top_test.sv */
`default_nettype none
module pec_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, resetn = 0, wr_en = 0, rd_en = 0, ring0 = 0, wr_err, rd_valid, rd_err;
  logic sleep_non_c0 = 0, halted = 0, stop_clock_pin = 0;
  logic first_level_thermal_throttle = 0, freq_switching = 0;
  logic [11:0] wr_addr = 0, rd_addr = 0, base, ms_attr;
  logic [31:0] wr_lo = 0, wr_hi = 0, sel, lo_v;
  logic [63:0] rd_data, exp_v;
  logic [1:0] global_en = 0;
  logic [6:0] pulse, evt_unavail;
  logic [7:0] ms_code;
  wire ref_tick, insn_retire, vm_exit, llc_ref, llc_miss, br_retire, br_misp, ms_evt;
  wire ms_q_core, ms_q_agent, ms_q_pf, ms_q_state, ms_this_core, ms_this_agent, ms_hw_pf;
  wire [3:0] ms_line_state;
  integer seed = 32'h0a79, err_count = 0, check_count = 0, k, n;
  logic [31:0] evt_tab [0:7] = '{32'h3C, 32'h13C, 32'hC0, 32'h4F2E, 32'h412E, 32'hC4, 32'hC5, 32'h80};
  assign {ref_tick, insn_retire, vm_exit, llc_ref, llc_miss, br_retire, br_misp} = pulse;
  assign {ms_evt, ms_q_core, ms_q_agent, ms_q_pf, ms_q_state, ms_this_core, ms_this_agent,
    ms_hw_pf, ms_line_state} = ms_attr;
  pec_top u_pec_top (.*);
  pec_src u_pec_src (.*);
  always #12.5 mclk = ~mclk;

  function automatic bit hit(logic [31:0] s);
    logic [7:0] u;
    logic run;
    u = s[15:8];
    run = !(sleep_non_c0 | halted | stop_clock_pin | first_level_thermal_throttle | freq_switching);
    if (!(s[22] && (ring0 ? s[17] : s[16]))) return 0;
    case (s[15:0])
      16'h003C: return run;
      16'h013C: return run && ref_tick;
      16'h00C0: return insn_retire && !vm_exit;
      16'h4F2E: return llc_ref;
      16'h412E: return llc_miss;
      16'h00C4: return br_retire;
      16'h00C5: return br_misp;
    endcase
    return ms_evt && ms_code == s[7:0]
      && (!ms_q_core || u[7:6] == 2'h3 || (u[7:6] == 2'h1 && ms_this_core))
      && (!ms_q_agent || u[5] || ms_this_agent)
      && (ms_q_agent || !ms_q_pf || u[5:4] == 2'h3 || u[5:4] == {1'b0, ms_hw_pf})
      && (!ms_q_state || |(u[3:0] & ms_line_state));
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] lo, hi, input logic e);
    @(posedge mclk);
    wr_en <= 1;
    {wr_addr, wr_lo, wr_hi} <= {a, lo, hi};
    @(posedge mclk);
    wr_en <= 0;
    #1 chk(wr_err, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [63:0] e, input logic ee);
    @(posedge mclk);
    rd_en <= 1;
    rd_addr <= a;
    @(posedge mclk);
    rd_en <= 0;
    #1 chk({rd_valid, rd_err}, {1'b1, ee});
    chk(rd_data, e);
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    err_count++;
    test_done;
  end

  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1;
    rd(12'h345, 64'h2000, 0);
    wr(12'h345, 0, 0, 1);
    rd(12'h0FF, 0, 1);
    chk(evt_unavail, 0);
    wr(12'h0C1, 32'h8000_0000, 0, 0);
    rd(12'h0C1, 64'hFFFF_FFFF_8000_0000, 0);
    for (k = 0; k < 48; k++) begin
      base = {11'h0, k[0]};
      sel = evt_tab[k % 8] | 32'h40_0000 | ($random(seed) & (k % 8 == 7 ? 32'h3FF00 : 32'h30000));
      @(posedge mclk);
      // one stop cause per even run; the writes below outlast the pin synchroniser
      {sleep_non_c0, halted, stop_clock_pin, first_level_thermal_throttle, freq_switching}
        <= k[0] ? 5'h0 : 5'h1 << ((k / 2) % 5);
      lo_v = $random(seed);
      if (k[1]) begin
        wr(12'h4C1 + base, 32'hFFFF_FFE0, $random(seed) | 32'hFFFF, 0);
        exp_v = 64'hFFFF_FFFF_FFFF_FFE0;
      end else begin
        wr(12'h0C1 + base, lo_v, $random(seed), 0);
        exp_v = {{32{lo_v[31]}}, lo_v};
      end
      wr(12'h186 + base, sel, 0, 0);
      for (n = 0; n < 40; n++) begin
        @(posedge mclk);
        if (global_en[k[0]] === 1'b1 && hit(sel)) exp_v++;
        global_en <= n < 39 ? $random(seed) : 0;
        ring0 <= $random(seed);
      end
      rd((k[2] ? 12'h4C1 : 12'h0C1) + base, {{16{exp_v[47]}}, exp_v[47:0]}, 0);
      rd(12'h186 + base, {32'h0, sel}, 0);
    end
    test_done;
  end
endmodule // pec_top_test
`default_nettype wire
